// ### core/dsf_regs.svh
// Constants for the disk status and track-format block.
// Included by the package and both ends; definitions only.
`ifndef DSF_REGS_SVH
`define DSF_REGS_SVH

// Status bit positions, positioning layout
`define DSF_BIT_NOT_READY   3'd7
`define DSF_BIT_PROTECT     3'd6
`define DSF_BIT_HEAD_LOADED 3'd5
`define DSF_BIT_SEEK_ERR    3'd4
`define DSF_BIT_CRC_ERR     3'd3
`define DSF_BIT_TRACK_ZERO  3'd2
`define DSF_BIT_INDEX       3'd1
`define DSF_BIT_BUSY        3'd0
// Status bit positions, transfer layout; status reset value
`define DSF_BIT_REC_TYPE    3'd5
`define DSF_BIT_WRITE_FAULT 3'd5
`define DSF_BIT_NOT_FOUND   3'd4
`define DSF_BIT_LOST_DATA   3'd2
`define DSF_BIT_REQUEST     3'd1
`define DSF_STATUS_RESET    8'h00
// Format control byte values and CRC settings
`define DSF_MARK_LOW        8'hf5
`define DSF_MARK_HIGH       8'hfe
`define DSF_CRC_CODE        8'hf7
`define DSF_FILL_BYTE       8'hff
`define DSF_ZERO_BYTE       8'h00
`define DSF_CRC_INIT        16'hffff
`define DSF_CRC_POLY        16'h1021
// Byte slot time on the drive side, 32 us per FM byte, 3200 cycles at 100 MHz
`define DSF_BYTE_TIME_NS    32000
`define DSF_BYTE_CYCLES     ((`DSF_BYTE_TIME_NS + 9) / 10)
// Bytes per track written before the closing index is awaited
`define DSF_TRACK_BYTES     16'd3125
`endif

// ### core/dsf_pkg.sv
// Types shared by both ends of the status/format block.
// Needs dsf_regs.svh on the include path.
`include "dsf_regs.svh"
package dsf_pkg;
  // Command class that selects the status layout
  typedef enum logic [2:0] {
    DSF_CMD_POSITION   = 3'h0,
    DSF_CMD_READ_SEC   = 3'h1,
    DSF_CMD_WRITE_SEC  = 3'h2,
    DSF_CMD_READ_ADDR  = 3'h3,
    DSF_CMD_READ_TRK   = 3'h4,
    DSF_CMD_WRITE_TRK  = 3'h5,
    DSF_CMD_ABORT      = 3'h6
  } dsf_cmd_t;

  // Write-track sequencer states
  typedef enum logic [3:0] {
    DSF_WT_IDLE  = 4'b0001,
    DSF_WT_WAIT  = 4'b0010,
    DSF_WT_BYTE  = 4'b0100,
    DSF_WT_CRC2  = 4'b1000
  } dsf_wt_state_t;
endpackage

// ### core/dsf_if.sv
// Interface joining the host end and the device end.
// Single clock; testbench ties clk, arst_n and clk_en.
`timescale 1ns/1ps
interface dsf_if
  import dsf_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en
);
  logic       cmd_start;             // One-cycle command strobe
  dsf_cmd_t   cmd_kind;              // Command class with strobe
  logic [3:0] abort_cond;            // Abort condition bits
  logic       status_read;           // One-cycle status read strobe
  logic [7:0] disk_status_word;      // Status word
  logic       data_write;            // One-cycle data byte strobe
  logic [7:0] data_byte;             // Data byte with strobe
  logic       byte_transfer_request; // Byte wanted
  logic       interrupt_request_out; // Interrupt level

  modport device (
    input  clk, arst_n, clk_en, cmd_start, cmd_kind, abort_cond, status_read,
           data_write, data_byte,
    output disk_status_word, byte_transfer_request, interrupt_request_out
  );
  modport host (
    input  clk, arst_n, clk_en, disk_status_word, byte_transfer_request,
           interrupt_request_out,
    output cmd_start, cmd_kind, abort_cond, status_read, data_write, data_byte
  );
endinterface // dsf_if

// ### core/dsf_device.sv
// Overview of operation
// - Non-abort start sets busy, refreshes other bits
// - Abort while busy clears busy and request only
// - Idle abort refreshes into positioning layout
// - Positioning layout: nrdy,wp,hl,seek,crc,tr0,idx,busy
// - Transfer layout: nrdy,lost,request,busy; errors per kind
// - Bits 6 and 5 depend on transfer kind
// - Not-ready bit follows drive ready
// - Protect bit set while protect sense low
// - Head loaded needs head load and engaged
// - Track-zero bit set while sense low
// - Index bit set while index sense low
// - Seek, not-found, CRC errors set, cleared on refresh
// - Lost data on missed request, cleared on refresh
// - Request bit shows pending request; write-track start sets it, other refresh clears
// - Host positions head, then feeds track bytes
// - Bytes F5 to FE are marks or CRC codes
// - Byte F7 writes two generated CRC bytes
// - Host layout: 128 or 256 byte sectors, 26
// - Host sends FF until sequence ends
// - Host custom sector sizes 128 to 1024
// - Host ID-to-data gap counts exact
// - Host minimum gap fills respected
// - Status read or command clears interrupt request; immediate interrupt held until abort with no condition
//
// Device end: status word and write-track formatter.
// Drive pins are synchronous to clk; error events come from the sequencers.
`timescale 1ns/1ps
`include "dsf_regs.svh"
module dsf_device
  import dsf_pkg::*;
(
  dsf_if.device     bus,
  input  wire logic drive_ready,
  input  wire logic protect_sense_n,
  input  wire logic outer_track_sense_n,
  input  wire logic index_sense_n,
  input  wire logic head_engaged_in,
  input  wire logic write_fault_in,
  input  wire logic seek_fail,
  input  wire logic sector_not_found,
  input  wire logic crc_fail,
  input  wire logic deleted_mark,
  input  wire logic cmd_done,
  output logic      head_load_out,
  output logic      write_gate,
  output logic [7:0] write_byte,
  output logic      write_strobe,
  output logic      address_marker
);
  logic           clk;
  logic           arst_n;
  logic           en;
  logic           busy;
  dsf_cmd_t       layout;
  logic           err_seek;
  logic           err_nf;
  logic           err_crc;
  logic           lost;
  logic           rec_type;
  logic           fault;
  logic           req;
  logic           imm_irq;
  logic           irq;
  logic           refresh;
  logic           abort_busy;
  logic           byte_tick;
  logic [15:0]    tick_cnt;
  logic [15:0]    byte_cnt;
  logic [15:0]    crc;
  logic [7:0]     held;
  logic           held_ok;
  logic           index_prev;
  logic           index_edge;
  logic           wt_end;
  logic [7:0]     next_out;
  dsf_wt_state_t  wt_state;
  logic [7:0]     sw;

  assign clk    = bus.clk;
  assign arst_n = bus.arst_n;
  assign en     = bus.clk_en;

  // Command start classification
  assign refresh    = bus.cmd_start &&
                      (bus.cmd_kind != DSF_CMD_ABORT || !busy);
  assign abort_busy = bus.cmd_start && bus.cmd_kind == DSF_CMD_ABORT && busy;
  assign index_edge = !index_sense_n && index_prev;

  // Busy bit and active layout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy   <= 1'b0;
      layout <= DSF_CMD_POSITION;
    end else if (en) begin
      if (abort_busy) begin
        busy <= 1'b0;
      end else if (refresh && bus.cmd_kind == DSF_CMD_ABORT) begin
        layout <= DSF_CMD_POSITION;
      end else if (refresh) begin
        busy   <= 1'b1;
        layout <= bus.cmd_kind;
      end else if (cmd_done || wt_end) begin
        busy <= 1'b0;
      end
    end
  end

  // Sticky error bits; event beats refresh
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_seek <= 1'b0;
      err_nf   <= 1'b0;
      err_crc  <= 1'b0;
      rec_type <= 1'b0;
      fault    <= 1'b0;
    end else if (en) begin
      err_seek <= (seek_fail && busy) || (err_seek && !refresh);
      err_nf   <= (sector_not_found && busy) || (err_nf && !refresh);
      err_crc  <= (crc_fail && busy) || (err_crc && !refresh);
      rec_type <= (deleted_mark && busy) || (rec_type && !refresh);
      fault    <= (write_fault_in && busy) || (fault && !refresh);
    end
  end

  // Data request and lost-data tracking
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req  <= 1'b0;
      lost <= 1'b0;
    end else if (en) begin
      if (refresh && bus.cmd_kind == DSF_CMD_WRITE_TRK) begin
        req <= 1'b1;
      end else if (refresh || abort_busy || wt_end) begin
        req <= 1'b0;
      end else if (bus.data_write) begin
        req <= 1'b0;
      end else if (byte_tick && wt_state == DSF_WT_BYTE) begin
        req <= 1'b1;
      end
      lost <= (byte_tick && wt_state == DSF_WT_BYTE && !held_ok)
              || (lost && !refresh);
    end
  end

  // Interrupt: set at end or immediate abort; cleared by read or command, immediate one by abort with no condition
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq     <= 1'b0;
      imm_irq <= 1'b0;
    end else if (en) begin
      if (bus.cmd_start && bus.cmd_kind == DSF_CMD_ABORT) begin
        // Only an abort with no condition drops a pending immediate interrupt
        imm_irq <= (bus.abort_cond != 4'h0) && (imm_irq || bus.abort_cond[3]);
        irq     <= (bus.abort_cond != 4'h0) && (imm_irq || bus.abort_cond[3]);
      end else if (cmd_done || wt_end) begin
        irq <= 1'b1;
      end else if ((bus.status_read || bus.cmd_start) && !imm_irq) begin
        irq <= 1'b0;
      end
    end
  end

  // Byte slot timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt   <= 16'h0000;
      index_prev <= 1'b1;
    end else if (en) begin
      index_prev <= index_sense_n;
      tick_cnt   <= byte_tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end
  assign byte_tick = tick_cnt == 16'(`DSF_BYTE_CYCLES - 1);

  // Holding register for host byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held    <= `DSF_ZERO_BYTE;
      held_ok <= 1'b0;
    end else if (en) begin
      if (bus.data_write) begin
        held    <= bus.data_byte;
        held_ok <= 1'b1;
      end else if (byte_tick && wt_state == DSF_WT_BYTE) begin
        held_ok <= 1'b0;
      end
    end
  end

  // Translate held byte: marks, CRC code or plain data
  always_comb begin
    next_out = held_ok ? held : `DSF_ZERO_BYTE;
    if (held_ok && held == `DSF_CRC_CODE) begin
      next_out = crc[15:8];
    end
  end

  // Write-track sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wt_state       <= DSF_WT_IDLE;
      byte_cnt       <= 16'h0000;
      crc            <= `DSF_CRC_INIT;
      write_byte     <= `DSF_FILL_BYTE;
      write_strobe   <= 1'b0;
      write_gate     <= 1'b0;
      address_marker <= 1'b0;
      wt_end         <= 1'b0;
    end else if (en) begin
      write_strobe <= 1'b0;
      wt_end       <= 1'b0;
      unique case (wt_state)
        DSF_WT_IDLE: begin
          if (refresh && bus.cmd_kind == DSF_CMD_WRITE_TRK) begin
            wt_state <= DSF_WT_WAIT;
          end
        end
        DSF_WT_WAIT: begin
          if (abort_busy) begin
            wt_state <= DSF_WT_IDLE;
          end else if (index_edge) begin
            byte_cnt   <= 16'h0000;
            wt_state   <= held_ok ? DSF_WT_BYTE : DSF_WT_IDLE;
            wt_end     <= !held_ok;
            write_gate <= held_ok && !protect_sense_n ? 1'b0 : held_ok;
          end
        end
        DSF_WT_BYTE: begin
          if (abort_busy || (index_edge && byte_cnt >= `DSF_TRACK_BYTES)) begin
            wt_state   <= DSF_WT_IDLE;
            write_gate <= 1'b0;
            wt_end     <= !abort_busy;
          end else if (byte_tick) begin
            write_byte     <= next_out;
            write_strobe   <= 1'b1;
            byte_cnt       <= byte_cnt + 16'h0001;
            address_marker <= held_ok && held >= `DSF_MARK_LOW
                              && held <= `DSF_MARK_HIGH && held != `DSF_CRC_CODE;
            if (held_ok && held == `DSF_CRC_CODE) begin
              wt_state <= DSF_WT_CRC2;
            end else if (held_ok && held >= `DSF_MARK_LOW && held <= `DSF_MARK_HIGH) begin
              crc <= `DSF_CRC_INIT;
            end else begin
              crc <= crc_step(crc, next_out);
            end
          end
        end
        DSF_WT_CRC2: begin
          if (abort_busy) begin
            wt_state   <= DSF_WT_IDLE;
            write_gate <= 1'b0;
          end else if (byte_tick) begin
            write_byte     <= crc[7:0];
            write_strobe   <= 1'b1;
            address_marker <= 1'b0;
            byte_cnt       <= byte_cnt + 16'h0001;
            crc            <= `DSF_CRC_INIT;
            wt_state       <= DSF_WT_BYTE;
          end
        end
      endcase
    end
  end

  // CRC-CCITT over one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ `DSF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Status word by active layout; drive bits are live
  always_comb begin
    sw = `DSF_STATUS_RESET;
    sw[`DSF_BIT_NOT_READY] = !drive_ready;
    sw[`DSF_BIT_BUSY]      = busy;
    unique case (layout)
      DSF_CMD_POSITION, DSF_CMD_ABORT: begin
        sw[`DSF_BIT_PROTECT]     = !protect_sense_n;
        sw[`DSF_BIT_HEAD_LOADED] = head_load_out && head_engaged_in;
        sw[`DSF_BIT_SEEK_ERR]    = err_seek;
        sw[`DSF_BIT_CRC_ERR]     = err_crc;
        sw[`DSF_BIT_TRACK_ZERO]  = !outer_track_sense_n;
        sw[`DSF_BIT_INDEX]       = !index_sense_n;
      end
      default: begin
        sw[`DSF_BIT_LOST_DATA] = lost;
        sw[`DSF_BIT_REQUEST]   = req;
        if (layout != DSF_CMD_READ_TRK && layout != DSF_CMD_WRITE_TRK) begin
          sw[`DSF_BIT_NOT_FOUND] = err_nf;
          sw[`DSF_BIT_CRC_ERR]   = err_crc;
        end
        if (layout == DSF_CMD_READ_SEC) begin
          sw[`DSF_BIT_REC_TYPE] = rec_type;
        end
        if (layout == DSF_CMD_WRITE_SEC || layout == DSF_CMD_WRITE_TRK) begin
          sw[`DSF_BIT_PROTECT]     = !protect_sense_n;
          sw[`DSF_BIT_WRITE_FAULT] = fault;
        end
      end
    endcase
  end

  // Head load follows busy; registered status output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      head_load_out        <= 1'b0;
      bus.disk_status_word <= `DSF_STATUS_RESET;
    end else if (en) begin
      head_load_out        <= busy;
      bus.disk_status_word <= sw;
    end
  end

  assign bus.byte_transfer_request = req;
  assign bus.interrupt_request_out = irq;
endmodule // dsf_device

// ### core/dsf_host.sv
// Host end: issues commands and feeds write-track bytes from a user port.
// Assumes the user supplies a formatted byte stream; ends with fill bytes.
`timescale 1ns/1ps
`include "dsf_regs.svh"
module dsf_host
  import dsf_pkg::*;
(
  dsf_if.host        bus,
  input  wire logic  user_cmd_valid,
  input  dsf_cmd_t   user_cmd_kind,
  input  wire logic [3:0] user_abort_cond,
  input  wire logic  user_read_status,
  input  wire logic  user_byte_valid,
  input  wire logic [7:0] user_byte,
  output logic       user_byte_ready,
  output logic [7:0] user_status,
  output logic       user_irq
);
  logic clk;
  logic arst_n;
  logic en;
  logic filling;
  logic pending;

  assign clk    = bus.clk;
  assign arst_n = bus.arst_n;
  assign en     = bus.clk_en;

  // Command and status strobes pass straight through
  assign bus.cmd_start   = user_cmd_valid;
  assign bus.cmd_kind    = user_cmd_kind;
  assign bus.abort_cond  = user_abort_cond;
  assign bus.status_read = user_read_status;
  // One byte per request; fill once the user stream stops
  assign user_byte_ready = pending && !filling && !bus.data_write;

  // Track request edges and fill mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
      filling <= 1'b0;
    end else if (en) begin
      if (user_cmd_valid) begin
        filling <= 1'b0;
        pending <= 1'b0;
      end else if (bus.interrupt_request_out) begin
        filling <= 1'b0;
        pending <= 1'b0;
      end else if (bus.data_write) begin
        pending <= 1'b0;
      end else if (bus.byte_transfer_request && !pending) begin
        pending <= 1'b1;
      end
      if (pending && !user_byte_valid && !filling && !bus.interrupt_request_out) begin
        filling <= user_cmd_valid ? 1'b0 : 1'b1;
      end
    end
  end

  // Data strobe and byte, registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.data_write <= 1'b0;
      bus.data_byte  <= `DSF_FILL_BYTE;
    end else if (en) begin
      bus.data_write <= pending && (user_byte_valid || filling) && !bus.data_write;
      if (pending && !bus.data_write) begin
        bus.data_byte <= filling ? `DSF_FILL_BYTE : user_byte;
      end
    end
  end

  // Mirror status and interrupt to the user side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      user_status <= `DSF_STATUS_RESET;
      user_irq    <= 1'b0;
    end else if (en) begin
      user_status <= bus.disk_status_word;
      user_irq    <= bus.interrupt_request_out;
    end
  end
endmodule // dsf_host

// ### sim/dsf_monitor.sv
// Checker on the signals between the host end and the device end.
// Instantiated by the testbench beside the interface; one clock domain.
`timescale 1ns/1ps
module dsf_monitor
  import dsf_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       clk_en,
  input wire logic       cmd_start,
  input dsf_cmd_t        cmd_kind,
  input wire logic [3:0] abort_cond,
  input wire logic       status_read,
  input wire logic [7:0] disk_status_word,
  input wire logic       data_write,
  input wire logic [7:0] data_byte,
  input wire logic       byte_transfer_request,
  input wire logic       interrupt_request_out
);
  dsf_cmd_t   kind_q;
  logic [1:0] age;
  logic       imm_q;
  logic       abort_go;

  assign abort_go = cmd_start && clk_en && (cmd_kind == DSF_CMD_ABORT);

  // Last command class and cycles since it was taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kind_q <= DSF_CMD_POSITION;
      age    <= 2'h0;
    end else if (cmd_start && clk_en) begin
      kind_q <= cmd_kind;
      age    <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  // Immediate-interrupt abort outstanding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      imm_q <= 1'b0;
    end else if (abort_go) begin
      imm_q <= (abort_cond == 4'h0) ? 1'b0 : (imm_q | abort_cond[3]);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_start_sets_busy: assert property (
    cmd_start && clk_en && cmd_kind != DSF_CMD_ABORT |-> ##2 disk_status_word[0])
    else $error("busy not set after command start");
  a_abort_clears_busy: assert property (
    abort_go ##1 !cmd_start |-> ##1 !disk_status_word[0])
    else $error("busy not cleared by abort");
  a_track_refresh: assert property (
    cmd_start && clk_en && (cmd_kind == DSF_CMD_WRITE_TRK || cmd_kind == DSF_CMD_READ_TRK)
    |-> ##2 disk_status_word[4:2] == 3'h0)
    else $error("status not refreshed by track command");
  a_wt_raises_req: assert property (
    cmd_start && clk_en && cmd_kind == DSF_CMD_WRITE_TRK |=> byte_transfer_request)
    else $error("no byte request after write track");
  a_write_drops_req: assert property (
    data_write |=> !byte_transfer_request)
    else $error("byte request stays after data write");
  a_host_waits_req: assert property (
    data_write |-> byte_transfer_request)
    else $error("data written without request");
  a_req_in_status: assert property (
    kind_q == DSF_CMD_WRITE_TRK && age == 2'h3
    |-> disk_status_word[1] == $past(byte_transfer_request))
    else $error("request bit does not follow request");
  a_wt_err_zero: assert property (
    kind_q == DSF_CMD_WRITE_TRK && age == 2'h3 |-> disk_status_word[4:3] == 2'h0)
    else $error("error bits set in write track layout");
  a_read_clears_irq: assert property (
    status_read && !imm_q && interrupt_request_out |-> ##[1:2] !interrupt_request_out)
    else $error("status read does not clear interrupt");
  a_imm_sets_irq: assert property (
    abort_go && abort_cond[3] |-> ##[1:2] interrupt_request_out)
    else $error("immediate abort raises no interrupt");
  a_imm_holds_irq: assert property (
    imm_q && interrupt_request_out && !cmd_start |=> interrupt_request_out)
    else $error("immediate interrupt dropped early");
endmodule // dsf_monitor

// ### sim/test_disk_status_and_format.sv
// Testbench: host end and device end joined by the interface.
// Drives the user side and drive pins; clk_en held high except for one frozen command at the end.
`timescale 1ns/1ps
module test_disk_status_and_format;
  import dsf_pkg::*;
  typedef struct packed {logic [5:0] p; logic [7:0] s;} dsf_row_t;

  logic       clk, arst_n, clk_en, user_cmd_valid, user_read_status, feed_on;
  dsf_cmd_t   user_cmd_kind;
  logic [3:0] user_abort_cond;
  logic [5:0] pins;  // ready, protect_n, track_n, index_n, engaged, fault
  logic [4:0] evt;   // seek, not found, crc, deleted, done
  logic       user_byte_valid, user_byte_ready, user_irq, write_strobe, address_marker;
  logic [7:0] user_byte, write_byte, st, b, us;
  logic       m, wg;
  logic [2:0] src_i = 3'h0;
  logic [7:0] src [4] = '{8'h00, 8'hfe, 8'h01, 8'hf7};
  logic [7:0] exp_b [6] = '{8'h00, 8'hfe, 8'h01, 8'hf1, 8'hd1, 8'hff};
  dsf_cmd_t   xk [4] = '{DSF_CMD_READ_SEC, DSF_CMD_WRITE_SEC, DSF_CMD_READ_ADDR,
                         DSF_CMD_READ_TRK};
  dsf_row_t   rows [6] = '{'{6'b111100, 8'h01}, '{6'b011100, 8'h81},
                           '{6'b101100, 8'h41}, '{6'b111110, 8'h21},
                           '{6'b110100, 8'h05}, '{6'b111000, 8'h03}};
  int         error_cnt = 0;
  int         num_checks = 0;

  dsf_if i_dsf_if (.clk(clk), .arst_n(arst_n), .clk_en(clk_en));
  dsf_host i_dsf_host (.bus(i_dsf_if.host), .user_cmd_valid, .user_cmd_kind,
    .user_abort_cond, .user_read_status, .user_byte_valid, .user_byte,
    .user_byte_ready, .user_status(us), .user_irq);
  dsf_device i_dsf_device (.bus(i_dsf_if.device), .drive_ready(pins[5]),
    .protect_sense_n(pins[4]), .outer_track_sense_n(pins[3]), .index_sense_n(pins[2]),
    .head_engaged_in(pins[1]), .write_fault_in(pins[0]), .seek_fail(evt[4]),
    .sector_not_found(evt[3]), .crc_fail(evt[2]), .deleted_mark(evt[1]),
    .cmd_done(evt[0]), .head_load_out(), .write_gate(wg), .write_byte, .write_strobe,
    .address_marker);
  dsf_monitor i_dsf_monitor (.clk, .arst_n, .clk_en, .cmd_start(i_dsf_if.cmd_start),
    .cmd_kind(i_dsf_if.cmd_kind), .abort_cond(i_dsf_if.abort_cond),
    .status_read(i_dsf_if.status_read), .disk_status_word(i_dsf_if.disk_status_word),
    .data_write(i_dsf_if.data_write), .data_byte(i_dsf_if.data_byte),
    .byte_transfer_request(i_dsf_if.byte_transfer_request),
    .interrupt_request_out(i_dsf_if.interrupt_request_out));

  assign st = i_dsf_if.disk_status_word;
  assign user_byte_valid = feed_on && (src_i < 3'h4);
  assign user_byte = src[src_i[1:0]];

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Format stream source, one byte per accepted handshake
  always @(posedge clk) begin
    if (user_byte_ready && user_byte_valid) src_i <= src_i + 3'h1;
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    chk8(what, {7'h0, e}, {7'h0, g});
  endtask
  task automatic cmd(input dsf_cmd_t k, input logic [3:0] c);
    @(posedge clk);
    user_cmd_valid  <= 1'b1;
    user_cmd_kind   <= k;
    user_abort_cond <= c;
    @(posedge clk);
    user_cmd_valid <= 1'b0;
    settle(5);
  endtask
  task automatic ev(input logic [4:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 5'h0;
    settle(4);
  endtask
  task automatic rd();
    @(posedge clk);
    user_read_status <= 1'b1;
    @(posedge clk);
    user_read_status <= 1'b0;
    settle(4);
  endtask
  task automatic grab();
    int n = 0;
    while (write_strobe !== 1'b1 && n < 4000) begin
      settle(1);
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      $display("[FAIL] write strobe expected 1 seen 0");
      finish_test();
    end else begin
      b = write_byte;
      m = address_marker;
      settle(1);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    {arst_n, clk_en, user_cmd_valid, user_read_status, feed_on} = 5'b01000;
    user_cmd_kind = DSF_CMD_POSITION;
    user_abort_cond = 4'h0;
    pins = 6'b111100;
    evt = 5'h0;
    settle(6);
    chk8("idle write byte", 8'hff, write_byte);
    chk1("reset irq", 1'b0, user_irq);
    @(posedge clk) arst_n <= 1'b1;
    cmd(DSF_CMD_POSITION, 4'h0);
    foreach (rows[i]) begin
      @(posedge clk) pins <= rows[i].p;
      settle(3);
      chk8("position status", rows[i].s, st);
    end
    @(posedge clk) pins <= 6'b111100;
    ev(5'b10100);
    chk8("seek crc set", 8'h19, st);
    cmd(DSF_CMD_ABORT, 4'h0);
    chk8("abort busy", 8'h18, st);
    cmd(DSF_CMD_POSITION, 4'h0);
    chk8("refresh", 8'h01, st);
    ev(5'b00001);
    chk1("done irq", 1'b1, user_irq);
    rd();
    chk1("read irq", 1'b0, user_irq);
    @(posedge clk) pins <= 6'b001101;
    foreach (xk[i]) begin
      cmd(xk[i], 4'h0);
      ev(5'b01110);
      chk8("transfer status", {1'b1, xk[i] == DSF_CMD_WRITE_SEC,
        xk[i] == DSF_CMD_READ_SEC || xk[i] == DSF_CMD_WRITE_SEC,
        {2{xk[i] != DSF_CMD_READ_TRK}}, 3'h1}, st & 8'hfd);
      ev(5'b00001);
      rd();
    end
    @(posedge clk) pins <= 6'b110000;
    cmd(DSF_CMD_ABORT, 4'h0);
    chk8("idle abort layout", 8'h06, st);
    chk8("user status", 8'h06, us);
    cmd(DSF_CMD_ABORT, 4'h8);
    rd();
    chk1("immediate irq held", 1'b1, user_irq);
    cmd(DSF_CMD_ABORT, 4'h0);
    chk1("immediate irq cleared", 1'b0, user_irq);
    @(posedge clk) pins <= 6'b111100;
    feed_on <= 1'b1;
    cmd(DSF_CMD_WRITE_TRK, 4'h0);
    chk8("track status", 8'h01, st & 8'hfd);
    settle(10);
    @(posedge clk) pins[2] <= 1'b0;
    for (int j = 0; j < 6; j++) begin
      grab();
      pins[2] <= 1'b1;
      chk1("marker", j == 1, m);
      chk8("track byte", exp_b[j], b);
      chk1("write gate", 1'b1, wg);
    end
    chk8("track lost", 8'h01, st & 8'hfd);
    cmd(DSF_CMD_ABORT, 4'h0);
    chk1("track abort busy", 1'b0, st[0]);
    chk1("gate after abort", 1'b0, wg);
    @(posedge clk) clk_en <= 1'b0;
    cmd(DSF_CMD_POSITION, 4'h0);
    @(posedge clk) clk_en <= 1'b1;
    settle(3);
    chk1("frozen command", 1'b0, st[0]);
    finish_test();
  end
endmodule // test_disk_status_and_format
